// ==== hdl/pft_pkg.sv ====
// pft_pkg: constants, modes and record types for the channel/frame tracker.
// assumes one 25 MHz core clock; all encoder sync inputs are synchronous to it.
package pft_pkg;
	// sequence geometry
	localparam int unsigned CHAN_W       = 5;                 // 32 channels per frame
	localparam int unsigned FRAME_W      = 4;                 // 16 frames per sequence
	localparam int unsigned NIB_W        = 4;                 // 16 tones, four bits each
	localparam int unsigned MAX_CHANS    = 6;                 // channels per data word
	localparam int unsigned CNT_W        = 3;
	localparam int unsigned WORD_W       = NIB_W * MAX_CHANS; // 24-bit data word
	localparam logic [CHAN_W-1:0]  LAST_CHAN  = 5'h1F;
	localparam logic [FRAME_W-1:0] LAST_FRAME = 4'hF;
	localparam logic [CNT_W-1:0]   CNT_MAX    = 3'h6;
	localparam logic [CNT_W-1:0]   CNT_PAIR   = 3'h2;
	localparam logic [CNT_W-1:0]   CNT_ONE    = 3'h1;
	localparam logic [CNT_W-1:0]   CNT_ZERO   = 3'h0;

	// timing: nominal channel period, slowest supported division, core clock
	localparam longint CHAN_PERIOD_NS = 10_000_000;           // 10 ms at 100 cps
	localparam longint SLOWEST_DIV    = 32;                   // 100/32 cps
	localparam longint CLK_PERIOD_NS  = 40;
	localparam int unsigned LOST_CYCLES_DEF =
		int'(CHAN_PERIOD_NS * SLOWEST_DIV / CLK_PERIOD_NS);

	localparam int unsigned FIFO_DEPTH = 16;

	// processing modes
	typedef enum logic [1:0] {
		PFT_MODE_MANUAL = 2'b00,
		PFT_MODE_AUTO   = 2'b01,
		PFT_MODE_ALL    = 2'b10
	} pft_mode_t;

	// one assembled datum with its location in the sequence
	typedef struct packed {
		logic [FRAME_W-1:0] frame;
		logic [CHAN_W-1:0]  first_chan;
		logic [CNT_W-1:0]   count;
		logic [WORD_W-1:0]  data;
	} pft_word_t;

	localparam int unsigned REC_W = $bits(pft_word_t);
endpackage : pft_pkg

// ==== hdl/pft_channel_frame_tracker.sv ====
// pft_channel_frame_tracker: channel/frame position tracking, nibble assembly,
// and a 16-word output FIFO for located data words.
// assumes tone level, sync-tone flag and sync strobes arrive synchronous to core_clk_i,
// with the recognised level held stable until the channel rate edge that ends it.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////////////////////////
// generic synchronous FIFO, valid/ready on both sides
module pft_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             core_clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q, rd_q;
	logic [AW:0]      fill_q;
	wire              push = in_valid_i && in_ready_o;
	wire              pop  = out_valid_o && out_ready_i;

	// honest flags straight from the fill count
	assign in_ready_o  = (fill_q != (AW+1)'(DEPTH));
	assign out_valid_o = (fill_q != '0);
	assign out_data_o  = mem_q[rd_q];

	// storage has no reset; only pointers and fill count carry state
	always_ff @(posedge core_clk_i) begin
		if (push) mem_q[wr_q] <= in_data_i;
	end

	// pointer and fill bookkeeping
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_q   <= '0;
			rd_q   <= '0;
			fill_q <= '0;
		end else begin
			if (push) wr_q <= AW'(wr_q + 1'b1);
			if (pop)  rd_q <= AW'(rd_q + 1'b1);
			fill_q <= (AW+1)'(fill_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
		end
	end
endmodule : pft_fifo

////////////////////////////////////////////////////////////////////////////////////////////////////
// top: position tracker and word assembler
module pft_channel_frame_tracker #(
	parameter int unsigned LOST_CYCLES = pft_pkg::LOST_CYCLES_DEF
) (
	input  wire logic                          core_clk_i,
	input  wire logic                          rst_n_i,
	input  wire logic                          chan_rate_i,
	input  wire logic                          seq_rate_i,
	input  wire logic                          auto_proc_i,
	input  wire logic [pft_pkg::NIB_W-1:0]     tone_level_i,
	input  wire logic                          sync_tone_i,
	input  wire pft_pkg::pft_mode_t            mode_i,
	input  wire logic                          complement_i,
	input  wire logic [pft_pkg::CHAN_W-1:0]    man_first_i,
	input  wire logic [pft_pkg::CNT_W-1:0]     man_count_i,
	input  wire logic [pft_pkg::FRAME_W-1:0]   man_frame_i,
	output logic      [pft_pkg::CHAN_W-1:0]    chan_o,
	output logic      [pft_pkg::FRAME_W-1:0]   frame_o,
	output logic                               sync_seen_o,
	output logic                               chan_lost_o,
	output logic                               overflow_o,
	output logic                               word_valid_o,
	input  wire logic                          word_ready_i,
	output pft_pkg::pft_word_t                 word_o
);
	import pft_pkg::*;

	logic                chan_d1_q, seq_d1_q;
	logic [CHAN_W-1:0]   ch_q;
	logic [FRAME_W-1:0]  fr_q;
	logic [CNT_W-1:0]    cnt_q;
	logic [WORD_W-1:0]   acc_q;
	logic [CHAN_W-1:0]   first_ch_q;
	logic [FRAME_W-1:0]  first_fr_q;
	pft_word_t           rec_q;
	logic                push_q, sync_q, ovf_q, lost_q;
	logic [31:0]         idle_q;
	logic                fifo_ready;

	////////////////////////////////////////////////////////////////////////////////////////////
	// strobe edges: only the rising edge of each sync line counts
	wire chan_edge = chan_rate_i && !chan_d1_q;
	wire seq_edge  = seq_rate_i && !seq_d1_q;
	wire tick      = chan_edge && !seq_edge;      // marker wins a tie

	// level to nibble, optionally complemented
	wire [NIB_W-1:0] nib = complement_i ? ~tone_level_i : tone_level_i;

	// channel selection per mode
	wire [CHAN_W-1:0] man_off  = CHAN_W'(ch_q - man_first_i);
	wire              man_sel  = (man_off < CHAN_W'(man_count_i)) && (fr_q == man_frame_i);
	wire              all_sel  = (cnt_q != CNT_ZERO) || !ch_q[0];
	wire              mode_sel = (mode_i == PFT_MODE_AUTO) ? auto_proc_i :
	                             (mode_i == PFT_MODE_ALL)  ? all_sel : man_sel;
	wire              take     = mode_sel && !sync_tone_i;
	wire [CNT_W-1:0]  limit    = (mode_i == PFT_MODE_ALL)    ? CNT_PAIR :
	                             (mode_i == PFT_MODE_MANUAL) ? man_count_i : CNT_MAX;

	// assembly: earliest nibble ends up highest, msb first
	wire [WORD_W-1:0] acc_base = (cnt_q == CNT_ZERO) ? '0 : acc_q;
	wire [WORD_W-1:0] acc_new  = {acc_base[WORD_W-NIB_W-1:0], nib};
	wire [CNT_W-1:0]  cnt_new  = CNT_W'(cnt_q + CNT_ONE);
	wire              full_now = take && (cnt_new >= limit || cnt_new == CNT_MAX);
	wire              emit     = tick && (full_now || (!take && cnt_q != CNT_ZERO));
	wire              fresh    = (cnt_q == CNT_ZERO);

	// record of the closing word with its location
	pft_word_t rec_d;
	assign rec_d.frame      = fresh ? fr_q : first_fr_q;
	assign rec_d.first_chan = fresh ? ch_q : first_ch_q;
	assign rec_d.count      = take ? cnt_new : cnt_q;
	assign rec_d.data       = take ? acc_new : acc_q;

	////////////////////////////////////////////////////////////////////////////////////////////
	// position counters
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			chan_d1_q <= 1'b0;
			seq_d1_q  <= 1'b0;
			ch_q      <= '0;
			fr_q      <= '0;
		end else begin
			chan_d1_q <= chan_rate_i;
			seq_d1_q  <= seq_rate_i;
			if (seq_edge) begin
				ch_q <= '0;
				fr_q <= '0;
			end else if (tick) begin
				ch_q <= CHAN_W'(ch_q + 1'b1);
				if (ch_q == LAST_CHAN) fr_q <= FRAME_W'(fr_q + 1'b1);
			end
		end
	end

	// accumulator; a partial word is dropped at the marker since it straddles sequences
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q      <= CNT_ZERO;
			acc_q      <= '0;
			first_ch_q <= '0;
			first_fr_q <= '0;
		end else if (seq_edge) begin
			cnt_q <= CNT_ZERO;
		end else if (tick) begin
			cnt_q <= (emit || !take) ? CNT_ZERO : cnt_new;
			if (take) acc_q <= acc_new;
			if (take && fresh) begin
				first_ch_q <= ch_q;
				first_fr_q <= fr_q;
			end
		end
	end

	// output record, status flags and channel-rate watchdog
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rec_q  <= '0;
			push_q <= 1'b0;
			sync_q <= 1'b0;
			ovf_q  <= 1'b0;
			idle_q <= '0;
			lost_q <= 1'b0;
		end else begin
			push_q <= emit;
			if (emit) rec_q <= rec_d;
			sync_q <= tick && sync_tone_i;
			if (push_q && !fifo_ready) ovf_q <= 1'b1;  // sticky: words lost while full
			// slowest rate is 1/32 of nominal, so silence beyond that means no encoder
			if (chan_edge) idle_q <= '0;
			else if (idle_q != LOST_CYCLES) idle_q <= idle_q + 32'h1;
			lost_q <= !chan_edge && (idle_q == LOST_CYCLES);
		end
	end

	assign chan_o      = ch_q;
	assign frame_o     = fr_q;
	assign sync_seen_o = sync_q;
	assign overflow_o  = ovf_q;
	assign chan_lost_o = lost_q;

	////////////////////////////////////////////////////////////////////////////////////////////
	// output buffer; a slow consumer back-pressures into the overflow flag
	pft_fifo #(
		.WIDTH (REC_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk_i  (core_clk_i),
		.rst_n_i     (rst_n_i),
		.in_valid_i  (push_q),
		.in_ready_o  (fifo_ready),
		.in_data_i   (rec_q),
		.out_valid_o (word_valid_o),
		.out_ready_i (word_ready_i),
		.out_data_o  (word_o)
	);

	////////////////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_tick;
		chan_edge && !seq_edge;
	endsequence
	sequence s_wrap;
		s_tick ##0 (ch_q == LAST_CHAN);
	endsequence

	AST_CHAN_ADV: assert property (s_tick |=> ch_q == CHAN_W'($past(ch_q) + 1'b1))
		else $error("channel counter did not advance");
	AST_FRAME_WRAP: assert property (s_wrap |=> ch_q == '0 && fr_q == FRAME_W'($past(fr_q) + 1'b1))
		else $error("frame did not advance on channel wrap");
	AST_SEQ_CLR: assert property (seq_edge |=> ch_q == '0 && fr_q == '0 && cnt_q == CNT_ZERO)
		else $error("marker did not realign counters");
	AST_MSB_FIRST: assert property ((s_tick ##0 take && !fresh && !emit) |=>
		acc_q == {$past(acc_q[WORD_W-NIB_W-1:0]), $past(nib)})
		else $error("nibble not shifted in at the low end");
	AST_COMPL: assert property ((s_tick ##0 take && fresh && !emit && complement_i) |=>
		acc_q == {{(WORD_W-NIB_W){1'b0}}, ~$past(tone_level_i)})
		else $error("complemented level not stored");
	AST_SYNC_SKIP: assert property ((s_tick ##0 sync_tone_i) |=> (cnt_q == CNT_ZERO && sync_q) ##1 sync_q == 1'b0)
		else $error("sync tone entered the data word");
	AST_AUTO_SEL: assert property ((s_tick ##0 mode_i == PFT_MODE_AUTO && !auto_proc_i) |=>
		cnt_q == CNT_ZERO)
		else $error("unmarked channel taken in automatic mode");
	AST_ALL_PAIR: assert property ((emit && mode_i == PFT_MODE_ALL) |=>
		push_q && rec_q.count == CNT_PAIR && !rec_q.first_chan[0])
		else $error("all-channel word not an even-started pair");
	AST_MAX6: assert property (cnt_q < CNT_MAX && rec_q.count <= CNT_MAX)
		else $error("word holds more than six channels");
	AST_LOC: assert property ((emit && !fresh) |=> rec_q.frame == $past(first_fr_q) &&
		rec_q.first_chan == $past(first_ch_q))
		else $error("word location not reported");
	AST_CHAN_TIME: assert property (chan_edge |=> idle_q == '0)
		else $error("channel timing not restarted on channel pulse");
	AST_EVERY_CHAN: assert property ((s_tick ##0 mode_i == PFT_MODE_ALL && !sync_tone_i
		&& !ch_q[0] && fresh) |=> cnt_q == CNT_ONE)
		else $error("data channel produced no symbol");
	AST_SLOW_RATE: assert property ((!chan_edge && idle_q < LOST_CYCLES) |=> !lost_q)
		else $error("slow channel rate flagged as lost");
	AST_NIB_BITS: assert property ((s_tick ##0 take && fresh && !emit && !complement_i) |=>
		acc_q == WORD_W'($past(tone_level_i)))
		else $error("four level bits not stored");
endmodule : pft_channel_frame_tracker

// ==== bench/pft_enc_model.sv ====
// pft_enc_model: encoder-side source of channel and sequence strobes and tones.
// assumes the bench calls its tasks just after a rising core clock edge.
`timescale 1ns/10ps
module pft_enc_model (
	input  wire logic                      core_clk_i,
	output logic                           chan_rate_o,
	output logic                           seq_rate_o,
	output logic                           auto_proc_o,
	output logic      [pft_pkg::NIB_W-1:0] tone_level_o,
	output logic                           sync_tone_o
);
	import pft_pkg::*;
	// strobes idle low from time zero
	initial begin
		chan_rate_o  = 1'b0;
		seq_rate_o   = 1'b0;
		auto_proc_o  = 1'b0;
		tone_level_o = 4'h0;
		sync_tone_o  = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// one channel; gap sets the rate, so a long gap is a divided-down channel rate
	task automatic send(input logic [NIB_W-1:0] lvl, input logic syn, input logic mark,
		input int gap);
		// wait first, so two calls in a row never drive a pin twice in one time step
		repeat (gap) @(posedge core_clk_i);
		#1 chan_rate_o = 1'b1;
		tone_level_o = lvl;
		sync_tone_o  = syn;
		auto_proc_o  = mark;
		@(posedge core_clk_i);
		#1 chan_rate_o = 1'b0;
		// held values expire: show the inverse so stale data cannot match
		tone_level_o = ~lvl;
		sync_tone_o  = ~syn;
		auto_proc_o  = ~mark;
	endtask : send
	// one sequence marker, one cycle wide
	task automatic mark_seq();
		@(posedge core_clk_i);
		#1 seq_rate_o = 1'b1;
		@(posedge core_clk_i);
		#1 seq_rate_o = 1'b0;
	endtask : mark_seq
endmodule : pft_enc_model

// ==== bench/pft_channel_frame_tracker_tb.sv ====
// pft_channel_frame_tracker_tb: self-checking bench for the tracker.
// assumes the encoder model drives all sync inputs; lost limit shortened to 50.
`timescale 1ns/10ps
module pft_channel_frame_tracker_tb;
	import pft_pkg::*;
	logic                core_clk, rst_n, complement, word_ready;
	logic                chan_rate, seq_rate, auto_proc, sync_tone;
	logic                sync_seen, chan_lost, overflow, word_valid;
	logic [NIB_W-1:0]    tone_level;
	logic [CHAN_W-1:0]   chan, man_first;
	logic [FRAME_W-1:0]  frame, man_frame;
	logic [CNT_W-1:0]    man_count;
	logic [WORD_W-1:0]   d;
	pft_mode_t           mode;
	pft_word_t           word;
	int                  err_count = 0, check_count = 0, sync_cnt = 0;
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	pft_enc_model i_enc (.core_clk_i(core_clk), .chan_rate_o(chan_rate), .seq_rate_o(seq_rate),
		.auto_proc_o(auto_proc), .tone_level_o(tone_level), .sync_tone_o(sync_tone));
	pft_channel_frame_tracker #(.LOST_CYCLES(50)) i_dut (.core_clk_i(core_clk),
		.rst_n_i(rst_n), .chan_rate_i(chan_rate), .seq_rate_i(seq_rate),
		.auto_proc_i(auto_proc), .tone_level_i(tone_level), .sync_tone_i(sync_tone),
		.mode_i(mode), .complement_i(complement), .man_first_i(man_first),
		.man_count_i(man_count), .man_frame_i(man_frame), .chan_o(chan), .frame_o(frame),
		.sync_seen_o(sync_seen), .chan_lost_o(chan_lost), .overflow_o(overflow),
		.word_valid_o(word_valid), .word_ready_i(word_ready), .word_o(word));
	// count sync pulses so a one-cycle pulse is never missed
	always @(posedge core_clk) if (sync_seen === 1'b1) sync_cnt++;
	////////////////////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : test_done
	task automatic chk(input string what, input logic [REC_W-1:0] exp, got);
		check_count++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			err_count++;
		end
	endtask : chk
	function automatic logic [NIB_W-1:0] lv(input logic [CHAN_W-1:0] c);
		return c[3:0] ^ 4'hA;
	endfunction : lv
	// take the head word after a bounded wait
	task automatic pop(input pft_word_t exp);
		int n;
		n = 0;
		while (word_valid !== 1'b1 && n < 20) begin
			cyc(1);
			n++;
		end
		if (n == 20) begin
			err_count++;
			test_done();
		end else begin
			chk("word", exp, word);
			word_ready = 1'b1;
			cyc(1);
			word_ready = 1'b0;
			// one idle edge so back-to-back pops never drive ready twice at once
			cyc(1);
		end
	endtask : pop
	////////////////////////////////////////////////////////////////////////////////
	// all mode, consumer stalled: 17 pairs overfill the 16-word buffer
	task automatic t_fill();
		mode = PFT_MODE_ALL;
		i_enc.mark_seq();
		for (int c = 0; c < 34; c++) i_enc.send(lv(5'(c)), 1'b0, 1'b0, 1);
		cyc(4);
		chk("chan", 5'h02, chan);
		chk("frame", 4'h1, frame);
		chk("overflow", 1'b1, overflow);
		for (int k = 0; k < 16; k++) pop({4'h0, 5'(2*k), 3'h2, 16'h0, lv(5'(2*k)), lv(5'(2*k+1))});
		chk("empty", 1'b0, word_valid);
		$display("done fill");
	endtask : t_fill
	// marker mid-pair drops the partial word and clears position
	task automatic t_realign();
		for (int c = 2; c < 5; c++) i_enc.send(lv(5'(c)), 1'b0, 1'b0, 1);
		i_enc.mark_seq();
		cyc(3);
		chk("chan", 5'h00, chan);
		chk("frame", 4'h0, frame);
		pop({4'h1, 5'h02, 3'h2, 16'h0, lv(5'h02), lv(5'h03)});
		cyc(3);
		chk("empty", 1'b0, word_valid);
		$display("done realign");
	endtask : t_realign
	// automatic mode at a slow rate, complemented, with a sync channel
	task automatic t_auto();
		mode = PFT_MODE_AUTO;
		complement = 1'b1;
		sync_cnt = 0;
		i_enc.send(4'h5, 1'b0, 1'b0, 40);
		i_enc.send(4'h7, 1'b1, 1'b0, 40);
		i_enc.send(4'h3, 1'b0, 1'b1, 40);
		i_enc.send(4'hC, 1'b0, 1'b1, 40);
		i_enc.send(4'h9, 1'b0, 1'b0, 40);
		cyc(4);
		chk("sync", 1, sync_cnt);
		pop({4'h0, 5'h02, 3'h2, 16'h0, 4'hC, 4'h3});
		cyc(60);
		chk("lost", 1'b1, chan_lost);
		i_enc.send(4'h1, 1'b0, 1'b0, 1);
		cyc(2);
		chk("lost", 1'b0, chan_lost);
		$display("done auto");
	endtask : t_auto
	// manual window of six channels gives a full 24-bit word
	task automatic t_manual();
		mode = PFT_MODE_MANUAL;
		complement = 1'b0;
		d = '0;
		i_enc.mark_seq();
		for (int c = 0; c < 12; c++) i_enc.send(lv(5'(c)), 1'b0, 1'b0, 1);
		for (int c = 5; c < 11; c++) d = {d[19:0], lv(5'(c))};
		cyc(4);
		pop({4'h0, 5'h05, 3'h6, d});
		$display("done manual");
	endtask : t_manual
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		mode = PFT_MODE_ALL;
		complement = 1'b0;
		word_ready = 1'b0;
		man_first = 5'h05;
		man_count = 3'h6;
		man_frame = 4'h0;
		repeat (20) @(posedge core_clk);
		#1 rst_n = 1'b1;
		cyc(1);
		chk("chan", 5'h00, chan);
		chk("valid", 1'b0, word_valid);
		$display("done reset");
		t_fill();
		t_realign();
		t_auto();
		t_manual();
		test_done();
	end
endmodule : pft_channel_frame_tracker_tb
